// File: pss_pkg.sv
// constants for the parallel/serial shift register block
// assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock
package pss_pkg;

  // ----------------------------------------------------------------
  // register geometry
  // ----------------------------------------------------------------
  localparam int unsigned STAGES       = 8;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFF      = 4'h0;
  localparam logic [3:0] STATUS_OFF    = 4'h4;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_HALT_BIT  = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam logic        CTRL_HALT_RST  = 1'h0;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_STAGE_LSB = 0;
  localparam int unsigned STAT_LAST_BIT  = 8;
  localparam int unsigned STAT_HALT_BIT  = 9;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;

endpackage

// File: pss_stage.sv
// one storage stage of the shift register
// assumes clear, take strobe and inputs all synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none

module pss_stage (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // control
  input  wire logic clear_i,
  input  wire logic take_i,
  input  wire logic load_i,
  // data
  input  wire logic par_bit_i,
  input  wire logic prev_bit_i,
  output var  logic q_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q_o <= 1'h0;
    end else if (ce_i) begin
      if (clear_i) begin
        q_o <= 1'h0;
      end else if (take_i) begin
        q_o <= load_i ? par_bit_i : prev_bit_i;
      end
    end
  end

endmodule // pss_stage

`default_nettype wire

// File: pss_top.sv
// parallel-load / serial-in shift register with AXI4-Lite control
// assumes device pins arrive synchronous to core_clk_i
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - high select shifts stages toward last
// - shift takes serial input into first
// - low select copies parallel inputs in
// - load happens only on clock edge
// - loading ignores serial input, no shift
// - clock inputs combined, update on rising
// - either clock input high holds stages
// - either input low lets other clock
// - low clear zeroes all stages, overrides
module pss_top (
  // clock, reset, enable
  input  wire  logic                        core_clk_i,
  input  wire  logic                        nrst_i,
  input  wire  logic                        ce_i,
  // device pins
  input  wire  logic                        clock_pin_i,
  input  wire  logic                        clock_gate_input_i,
  input  wire  logic                        shift_or_load_select_i,
  input  wire  logic                        serial_in_i,
  input  wire  logic [pss_pkg::STAGES-1:0]  parallel_in_i,
  input  wire  logic                        clear_n_i,
  output var   logic                        last_stage_out_o,
  // axi4-lite write address
  input  wire  logic                        s_axi_awvalid,
  output var   logic                        s_axi_awready,
  input  wire  logic [pss_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire  logic [2:0]                  s_axi_awprot,
  // axi4-lite write data
  input  wire  logic                        s_axi_wvalid,
  output var   logic                        s_axi_wready,
  input  wire  logic [pss_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire  logic [3:0]                  s_axi_wstrb,
  // axi4-lite write response
  output var   logic                        s_axi_bvalid,
  input  wire  logic                        s_axi_bready,
  output var   logic [1:0]                  s_axi_bresp,
  // axi4-lite read
  input  wire  logic                        s_axi_arvalid,
  output var   logic                        s_axi_arready,
  input  wire  logic [pss_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire  logic [2:0]                  s_axi_arprot,
  output var   logic                        s_axi_rvalid,
  input  wire  logic                        s_axi_rready,
  output var   logic [pss_pkg::DATA_W-1:0]  s_axi_rdata,
  output var   logic [1:0]                  s_axi_rresp
);
  import pss_pkg::*;

  logic [STAGES-1:0]  stage_w;
  logic               halt_q;
  logic               soft_clear_q;
  logic               comb_clk_q;
  logic               comb_clk;
  logic               take;
  logic               clear_any;
  logic               aw_hs;
  logic               w_hs;
  logic               aw_got_q;
  logic               w_got_q;
  logic               aw_got_d;
  logic               w_got_d;
  logic               bvalid_d;
  logic               do_write;
  logic [ADDR_W-1:0]  waddr_q;
  logic [DATA_W-1:0]  wdata_q;
  logic [3:0]         wstrb_q;
  logic [DATA_W-1:0]  status_word;

  // ----------------------------------------------------------------
  // clock combination
  // ----------------------------------------------------------------
  // the two clock pins and halt_q are or-ed; a rising edge of the or, seen on core_clk_i,
  // gives the stages a one-cycle take strobe, so an update lands on a rising clock pin while gate is low
  assign comb_clk  = clock_pin_i | clock_gate_input_i | halt_q;
  // rising edge only; a held-high input keeps comb_clk high
  assign take      = comb_clk & ~comb_clk_q;
  assign clear_any = ~clear_n_i | soft_clear_q;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      // starting high avoids a spurious edge right after reset
      comb_clk_q <= 1'h1;
    end else if (ce_i) begin
      comb_clk_q <= comb_clk;
    end
  end

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  for (genvar k = 0; k < STAGES; k++) begin : g_stage
    pss_stage u_stage (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .ce_i       (ce_i),
      .clear_i    (clear_any),
      .take_i     (take),
      .load_i     (~shift_or_load_select_i),
      .par_bit_i  (parallel_in_i[k]),
      .prev_bit_i ((k == 0) ? serial_in_i : stage_w[(k == 0) ? 0 : k-1]),
      .q_o        (stage_w[k])
    );
  end

  // last stage flop drives the pin directly
  assign last_stage_out_o = stage_w[STAGES-1];

  // ----------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------
  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign aw_got_d = (aw_got_q | aw_hs) & ~do_write;
  assign w_got_d  = (w_got_q | w_hs) & ~do_write;
  assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      aw_got_q      <= 1'h0;
      w_got_q       <= 1'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= 4'h0;
    end else if (ce_i) begin
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      // one write in flight: ready drops once a channel is held
      s_axi_awready <= ~aw_got_d & ~bvalid_d & ~do_write;
      s_axi_wready  <= ~w_got_d & ~bvalid_d & ~do_write;
      s_axi_bvalid  <= bvalid_d;
      if (aw_hs) begin
        waddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= (waddr_q == CTRL_OFF || waddr_q == STATUS_OFF) ?
                       RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      halt_q       <= CTRL_HALT_RST;
      soft_clear_q <= 1'h0;
    end else if (ce_i) begin
      soft_clear_q <= 1'h0;
      if (do_write && waddr_q == CTRL_OFF && wstrb_q[0]) begin
        halt_q       <= wdata_q[CTRL_HALT_BIT];
        // self-clearing, one cycle of clear
        soft_clear_q <= wdata_q[CTRL_CLEAR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word                             = '0;
    status_word[STAT_STAGE_LSB +: STAGES]   = stage_w;
    status_word[STAT_LAST_BIT]              = stage_w[STAGES-1];
    status_word[STAT_HALT_BIT]              = halt_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'h0;
        s_axi_rvalid  <= 1'h1;
        s_axi_rresp   <= RESP_OKAY;
        case (s_axi_araddr)
          CTRL_OFF: begin
            s_axi_rdata <= {{(DATA_W-1){1'b0}}, halt_q};
          end
          STATUS_OFF: begin
            s_axi_rdata <= status_word;
          end
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'h0;
          s_axi_arready <= 1'h1;
        end
      end else begin
        s_axi_arready <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_shift;
    ce_i && take && shift_or_load_select_i && !clear_any
      |=> stage_w[STAGES-1:1] == $past(stage_w[STAGES-2:0]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("stages did not shift toward last");

  property p_serial;
    ce_i && take && shift_or_load_select_i && !clear_any
      |=> stage_w[0] == $past(serial_in_i);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial bit not taken into first stage");

  property p_load;
    ce_i && take && !shift_or_load_select_i && !clear_any
      |=> stage_w == $past(parallel_in_i);
  endproperty
  a_load: assert property (p_load)
    else $error("parallel load mismatch");

  property p_load_sync;
    ce_i && !take && !shift_or_load_select_i && !clear_any
      |=> $stable(stage_w);
  endproperty
  a_load_sync: assert property (p_load_sync)
    else $error("load happened without clock edge");

  property p_ignore_serial;
    ce_i && take && !shift_or_load_select_i && !clear_any
      && serial_in_i != parallel_in_i[0]
      |=> stage_w[0] != $past(serial_in_i);
  endproperty
  a_ignore_serial: assert property (p_ignore_serial)
    else $error("serial input leaked into load");

  property p_held_high;
    ce_i && comb_clk_q && (clock_pin_i || clock_gate_input_i)
      && !clear_any |=> $stable(stage_w);
  endproperty
  a_held_high: assert property (p_held_high)
    else $error("stages moved while a clock input was held high");

  property p_gate_edge;
    ce_i && !clock_pin_i && clock_gate_input_i && !comb_clk_q
      && shift_or_load_select_i && !clear_any
      |=> stage_w[0] == $past(serial_in_i);
  endproperty
  a_gate_edge: assert property (p_gate_edge)
    else $error("gate input did not act as clock");

  property p_clear;
    ce_i && !clear_n_i |=> stage_w == '0 && !last_stage_out_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero the stages");

  property p_hold;
    ce_i && clear_n_i && !soft_clear_q && !take |=> $stable(stage_w);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stages changed without an edge");

  property p_freeze;
    !ce_i |=> $stable(stage_w);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("stages moved while enable was low");

endmodule // pss_top

`default_nettype wire

// File: pss_pin_model.sv
// pin-level model of the logic that drives the shift register pins
// assumes core_clk_i is the register block's system clock
`timescale 1ns/1ps
`default_nettype none

module pss_pin_model (
  // clock
  input  wire logic       core_clk_i,
  // pins toward the register
  output var  logic       clock_pin_o,
  output var  logic       gate_o,
  output var  logic       sel_o,
  output var  logic       ser_o,
  output var  logic [7:0] par_o,
  output var  logic       clear_n_o
);
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  initial begin
    // idle: gate held high, shift selected, clear released
    {clock_pin_o, gate_o, sel_o, ser_o, clear_n_o, par_o} = 13'h0d00;
  end

  // one core cycle of pin levels, changed just after the edge
  task automatic drive(input logic ck, g, sel, serial_in, cn,
                       input logic [7:0] par);
    @(posedge core_clk_i);
    {clock_pin_o, gate_o, sel_o, ser_o, clear_n_o, par_o} <=
      {ck, g, sel, serial_in, cn, par};
  endtask

  // stop the register: clock first, gate only while clock high
  task automatic halt_pins();
    drive(1'b1, gate_o, sel_o, ser_o, clear_n_o, par_o);
    drive(1'b1, 1'b1, sel_o, ser_o, clear_n_o, par_o);
  endtask
endmodule // pss_pin_model

`default_nettype wire

// File: pss_top_tb.sv
// self-checking bench for the shift register block
// assumes pss_top, pss_pkg and pss_pin_model are compiled first
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); err_count++; end end

module pss_top_tb;
  import pss_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk     = 1'b0;
  logic        nrst    = 1'b0;
  logic        ce      = 1'b1;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  awaddr  = 4'h0;
  logic [3:0]  araddr  = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, last;
  logic        ck, g, sel, serial_in, cn;
  logic [7:0]  par;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          err_count = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  pss_pin_model i_pm (.core_clk_i(clk), .clock_pin_o(ck), .gate_o(g),
    .sel_o(sel), .ser_o(serial_in), .par_o(par), .clear_n_o(cn));

  pss_top i_dut (.core_clk_i(clk), .nrst_i(nrst), .ce_i(ce),
    .clock_pin_i(ck), .clock_gate_input_i(g), .shift_or_load_select_i(sel),
    .serial_in_i(serial_in), .parallel_in_i(par), .clear_n_i(cn),
    .last_stage_out_o(last), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    {araddr, arvalid} <= {a, 1'b1};
    do @(posedge clk); while (arready !== 1'b1);
    {arvalid, rready} <= 2'b01;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // status bits 9:0 are halt, last stage, stages
  task automatic chk_reg(input logic [9:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(STATUS_OFF, d, r);
    `CHK("status", e, d[9:0])
    `CHK("last_stage_out", e[8], last)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_load();
    i_pm.drive(0, 0, 0, 1, 1, 8'h96);
    chk_reg(10'h000);
    i_pm.drive(1, 0, 0, 1, 1, 8'h96);
    chk_reg(10'h196);
    $display("test load done");
  endtask

  task automatic t_shift();
    logic [7:0] e;
    e = 8'h96;
    repeat (3) begin
      e = {e[6:0], 1'b1};
      i_pm.drive(0, 0, 1, 1, 1, 8'h00);
      i_pm.drive(1, 0, 1, 1, 1, 8'h00);
      chk_reg({1'b0, e[7], e});
    end
    $display("test shift done");
  endtask

  task automatic t_inhibit();
    i_pm.halt_pins();
    i_pm.drive(0, 1, 1, 0, 1, 8'h00);
    i_pm.drive(1, 1, 1, 0, 1, 8'h00);
    chk_reg(10'h1b7);
    i_pm.drive(1, 0, 1, 0, 1, 8'h00);
    i_pm.drive(1, 1, 1, 0, 1, 8'h00);
    chk_reg(10'h1b7);
    i_pm.drive(0, 0, 1, 0, 1, 8'h00);
    i_pm.drive(0, 1, 1, 0, 1, 8'h00);
    chk_reg(10'h06e);
    $display("test inhibit done");
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    i_pm.drive(0, 0, 1, 1, 1, 8'h00);
    i_pm.drive(1, 0, 1, 1, 1, 8'h00);
    chk_reg(10'h26e);
    wr(CTRL_OFF, 32'h0, RESP_OKAY);
    wr(STATUS_OFF, 32'h0, RESP_OKAY);
    chk_reg(10'h06e);
    rd(4'h8, d, r);
    `CHK("unmapped resp", RESP_DECERR, r)
    `CHK("unmapped data", 32'h0, d)
    wr(4'hc, 32'h0, RESP_DECERR);
    wr(CTRL_OFF, 32'h2, RESP_OKAY);
    chk_reg(10'h000);
    $display("test bus done");
  endtask

  task automatic t_clear();
    i_pm.drive(0, 0, 0, 0, 1, 8'hff);
    i_pm.drive(1, 0, 0, 0, 1, 8'hff);
    chk_reg(10'h1ff);
    i_pm.drive(0, 0, 0, 0, 1, 8'hff);
    i_pm.drive(1, 0, 0, 0, 0, 8'hff);
    i_pm.drive(1, 0, 0, 0, 1, 8'hff);
    chk_reg(10'h000);
    $display("test clear done");
  endtask

  // enable low must swallow a clock pin rise and a load request
  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    i_pm.drive(0, 0, 0, 0, 1, 8'hff);
    i_pm.drive(1, 0, 0, 0, 1, 8'hff);
    @(posedge clk);
    @(posedge clk);
    `CHK("frozen last", 1'b0, last)
    ce <= 1'b1;
    chk_reg(10'h000);
    $display("test enable done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_load();
    t_shift();
    t_inhibit();
    t_bus();
    t_clear();
    t_ce();
    results();
  end

  // tests need well under 400 cycles; a hang ends here
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    results();
  end
endmodule // pss_top_tb

`default_nettype wire
